//--- brake_sequencer_pwm.sv
// brake_sequencer_pwm: holding-brake control with automatic power-up/down sequencing
// assumes op_enable reflects the operation-enabled power state, inputs are synchronous
//
// Overview of operation
// [RULE1] auto mode releases brake only when enabled
// [RULE2] control bit 2 selects automatic sequencing
// [RULE3] manual mode: brake follows output bit 0
// [RULE4] enable: current, release delay, release, settle
// [RULE5] disable: standstill, engage delay, brake, hold
// [RULE6] switched-on brake output is pwm modulated
// [RULE7] pwm frequency in hertz, at most 2000
// [RULE8] duty cycle percent limited to 2..100
// [RULE9] duty 100 holds output steadily on
// [RULE10] ms delays; settings change at period boundary
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps

module brake_sequencer_pwm #(
	parameter int unsigned MS_CYCLES = brake_pkg::MS_CYCLES // clock cycles per millisecond
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic op_enable,
	input wire logic motor_standstill,
	output logic [31:0] reg_rdata_q,
	output logic motor_current_q,
	output logic travel_enable_q,
	output logic stop_request_q,
	output logic brake_pwm
);

	////////////////////////////////////////////////////////////////
	// helpers

	// bound a written value to a legal range
	function automatic logic [15:0] clamp16(input logic [31:0] v, input logic [15:0] lo, input logic [15:0] hi);
		if (v < {16'h0000, lo}) begin
			return lo;
		end else if (v > {16'h0000, hi}) begin
			return hi;
		end
		return v[15:0];
	endfunction

	// states in which automatic control keeps the brake released
	function automatic logic released(input brake_pkg::seq_state_t s);
		return (s == brake_pkg::ST_SETTLE) || (s == brake_pkg::ST_RUN) ||
			(s == brake_pkg::ST_STOP) || (s == brake_pkg::ST_ENGAGE_WAIT);
	endfunction

	////////////////////////////////////////////////////////////////
	// register file state
	logic auto_q; // automatic brake control
	logic auto_d;
	logic man_q; // manual brake bit of the digital outputs
	logic man_d;
	logic [15:0] dly_q [4]; // engage, hold, release, settle in ms
	logic [15:0] dly_d [4];
	brake_pkg::brake_cfg_t cfg_q; // pwm frequency and duty
	brake_pkg::brake_cfg_t cfg_d;
	logic [31:0] rdata_d;

	// sequencer state
	brake_pkg::seq_state_t state_q;
	brake_pkg::seq_state_t state_d;
	logic [31:0] pre_q; // millisecond prescaler
	logic [31:0] pre_d;
	logic [15:0] ms_q; // remaining milliseconds of the running delay
	logic [15:0] ms_d;
	logic brake_on_q; // brake energised, i.e. released
	logic brake_on_d;
	logic current_d;
	logic travel_d;
	logic stop_d;
	logic ms_tick;
	logic done;

	////////////////////////////////////////////////////////////////
	// register writes and reads
	always_comb begin
		auto_d = auto_q;
		man_d = man_q;
		cfg_d = cfg_q;
		for (int i = 0; i < 4; i++) begin
			dly_d[i] = dly_q[i];
		end
		if (reg_wr) begin
			case (reg_addr)
				brake_pkg::OFS_CTRL: begin
					// [RULE2] mode select bit
					auto_d = reg_wdata[brake_pkg::AUTO_BIT];
				end
				brake_pkg::OFS_DOUT: man_d = reg_wdata[brake_pkg::MANUAL_BRAKE_BIT];
				brake_pkg::OFS_DLY_ENGAGE: dly_d[brake_pkg::DLY_ENGAGE] = reg_wdata[15:0];
				brake_pkg::OFS_DLY_HOLD: dly_d[brake_pkg::DLY_HOLD] = reg_wdata[15:0];
				brake_pkg::OFS_DLY_RELEASE: dly_d[brake_pkg::DLY_RELEASE] = reg_wdata[15:0];
				brake_pkg::OFS_DLY_SETTLE: dly_d[brake_pkg::DLY_SETTLE] = reg_wdata[15:0];
				brake_pkg::OFS_PWM_FREQ: begin
					// [RULE7] frequency capped at 2000 hz
					cfg_d.freq = clamp16(reg_wdata, brake_pkg::FREQ_MIN, brake_pkg::FREQ_MAX);
				end
				brake_pkg::OFS_PWM_DUTY: begin
					// [RULE8] duty held in 2..100
					cfg_d.duty = 8'(clamp16(reg_wdata, 16'(brake_pkg::DUTY_MIN), 16'(brake_pkg::DUTY_MAX)));
				end
				default: ; // unmapped writes are dropped
			endcase
		end
		// read data stands only in the cycle after the strobe
		rdata_d = '0;
		if (reg_rd) begin
			case (reg_addr)
				brake_pkg::OFS_CTRL: rdata_d[brake_pkg::AUTO_BIT] = auto_q;
				brake_pkg::OFS_DOUT: rdata_d[brake_pkg::MANUAL_BRAKE_BIT] = man_q;
				brake_pkg::OFS_DLY_ENGAGE: rdata_d[15:0] = dly_q[brake_pkg::DLY_ENGAGE];
				brake_pkg::OFS_DLY_HOLD: rdata_d[15:0] = dly_q[brake_pkg::DLY_HOLD];
				brake_pkg::OFS_DLY_RELEASE: rdata_d[15:0] = dly_q[brake_pkg::DLY_RELEASE];
				brake_pkg::OFS_DLY_SETTLE: rdata_d[15:0] = dly_q[brake_pkg::DLY_SETTLE];
				brake_pkg::OFS_PWM_FREQ: rdata_d[15:0] = cfg_q.freq;
				brake_pkg::OFS_PWM_DUTY: rdata_d[7:0] = cfg_q.duty;
				brake_pkg::OFS_STATUS: begin
					// live sequencer and output state
					rdata_d[2:0] = state_q;
					rdata_d[4] = brake_on_q;
					rdata_d[5] = motor_current_q;
					rdata_d[6] = travel_enable_q;
					rdata_d[7] = stop_request_q;
					rdata_d[8] = op_enable;
				end
				default: rdata_d = '0; // unmapped reads return zero
			endcase
		end
	end

	// register file flops
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			auto_q <= brake_pkg::RST_AUTO;
			man_q <= 1'b0;
			cfg_q <= '{freq: brake_pkg::RST_FREQ, duty: brake_pkg::RST_DUTY};
			for (int i = 0; i < 4; i++) begin
				dly_q[i] <= brake_pkg::RST_DELAY;
			end
			reg_rdata_q <= '0;
		end else begin
			auto_q <= auto_d;
			man_q <= man_d;
			cfg_q <= cfg_d;
			for (int i = 0; i < 4; i++) begin
				dly_q[i] <= dly_d[i];
			end
			reg_rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// brake sequencer
	always_comb begin
		// [RULE10] millisecond time base
		ms_tick = (pre_q == MS_CYCLES - 1);
		done = (ms_q == 16'h0000);
		pre_d = ms_tick ? '0 : pre_q + 32'h1;
		ms_d = (ms_tick && !done) ? ms_q - 16'h0001 : ms_q;
		state_d = state_q;
		case (state_q)
			brake_pkg::ST_OFF: begin
				// [RULE4] current on, then release delay
				if (op_enable) begin
					state_d = brake_pkg::ST_RELEASE_WAIT;
					ms_d = dly_q[brake_pkg::DLY_RELEASE];
					pre_d = '0;
				end
			end
			brake_pkg::ST_RELEASE_WAIT: begin
				if (!op_enable) begin
					// [RULE1] brake never opened: keep it shut, go to hold delay
					state_d = brake_pkg::ST_HOLD_WAIT;
					ms_d = dly_q[brake_pkg::DLY_HOLD];
					pre_d = '0;
				end else if (done) begin
					// [RULE4] release, then settle delay
					state_d = brake_pkg::ST_SETTLE;
					ms_d = dly_q[brake_pkg::DLY_SETTLE];
					pre_d = '0;
				end
			end
			brake_pkg::ST_SETTLE: begin
				if (!op_enable) begin
					state_d = brake_pkg::ST_STOP;
				end else if (done) begin
					state_d = brake_pkg::ST_RUN;
				end
			end
			brake_pkg::ST_RUN: begin
				// [RULE5] leaving enable stops the motor first
				if (!op_enable) begin
					state_d = brake_pkg::ST_STOP;
				end
			end
			brake_pkg::ST_STOP: begin
				if (motor_standstill) begin
					// [RULE5] standstill, then engage delay
					state_d = brake_pkg::ST_ENGAGE_WAIT;
					ms_d = dly_q[brake_pkg::DLY_ENGAGE];
					pre_d = '0;
				end
			end
			brake_pkg::ST_ENGAGE_WAIT: begin
				if (done) begin
					// [RULE5] apply brake, then hold delay
					state_d = brake_pkg::ST_HOLD_WAIT;
					ms_d = dly_q[brake_pkg::DLY_HOLD];
					pre_d = '0;
				end
			end
			brake_pkg::ST_HOLD_WAIT: begin
				// [RULE5] current off after hold delay
				if (done) begin
					state_d = brake_pkg::ST_OFF;
				end
			end
			default: state_d = brake_pkg::ST_OFF;
		endcase
		current_d = (state_d != brake_pkg::ST_OFF);
		travel_d = (state_d == brake_pkg::ST_RUN);
		stop_d = (state_d == brake_pkg::ST_STOP);
		// [RULE1] auto: released only in the enable path
		// [RULE3] manual: brake follows output bit 0
		brake_on_d = auto_d ? released(state_d) : man_d;
	end

	// sequencer flops
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= brake_pkg::ST_OFF;
			pre_q <= '0;
			ms_q <= '0;
			brake_on_q <= 1'b0;
			motor_current_q <= 1'b0;
			travel_enable_q <= 1'b0;
			stop_request_q <= 1'b0;
		end else begin
			state_q <= state_d;
			pre_q <= pre_d;
			ms_q <= ms_d;
			brake_on_q <= brake_on_d;
			motor_current_q <= current_d;
			travel_enable_q <= travel_d;
			stop_request_q <= stop_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// brake output modulation
	// [RULE6] pwm runs while the brake is on
	brake_pwm_gen u_pwm (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.en(brake_on_q),
		.cfg(cfg_q),
		.pwm_q(brake_pwm)
	);

	////////////////////////////////////////////////////////////////
	// checks
	a_auto_brake_closed: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE1
		auto_q && (state_q == brake_pkg::ST_OFF || state_q == brake_pkg::ST_RELEASE_WAIT ||
		state_q == brake_pkg::ST_HOLD_WAIT) |-> !brake_on_q)
		else $error("brake released outside the enable path");
	a_mode_select: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE2
		reg_wr && reg_addr == brake_pkg::OFS_CTRL |=> auto_q == $past(reg_wdata[2]))
		else $error("mode bit not taken from bit 2");
	a_manual_follow: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE3
		!auto_q |-> brake_on_q == man_q) else $error("manual brake does not follow output bit");
	a_release_order: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE4
		auto_q && $rose(brake_on_q) |-> $past(motor_current_q))
		else $error("brake released before motor current");
	a_travel_after_settle: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE4
		$rose(travel_enable_q) |-> !auto_q || (brake_on_q && $past(state_q == brake_pkg::ST_SETTLE)))
		else $error("travel enabled without settle phase");
	a_current_off_order: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE5
		$fell(motor_current_q) |-> $past(state_q == brake_pkg::ST_HOLD_WAIT) && (!auto_q || !brake_on_q))
		else $error("motor current off before brake hold");
	a_freq_limit: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE7
		cfg_q.freq <= brake_pkg::FREQ_MAX && cfg_q.freq >= brake_pkg::FREQ_MIN)
		else $error("pwm frequency above 2000 hz");
	a_duty_range: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE8
		cfg_q.duty >= brake_pkg::DUTY_MIN && cfg_q.duty <= brake_pkg::DUTY_MAX)
		else $error("duty cycle outside 2..100");
	a_ms_tick_period: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE10
		ms_tick && state_q == state_d |=> pre_q == 0) else $error("millisecond prescaler did not wrap");

endmodule

//--- brake_pkg.sv
// brake_pkg: shared constants and types for the holding-brake sequencer
// assumes a single 40 MHz core clock and a plain byte-addressed register port
package brake_pkg;

	// clock and time base
	localparam int unsigned CLK_HZ = 40000000;
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned MS_NS = 1000000;
	localparam int unsigned MS_CYCLES = MS_NS / CLK_PERIOD_NS;

	// brake pwm limits
	localparam logic [15:0] FREQ_MIN = 16'h0001;
	localparam logic [15:0] FREQ_MAX = 16'h07d0;
	localparam logic [7:0] DUTY_MIN = 8'h02;
	localparam logic [7:0] DUTY_MAX = 8'h64;
	localparam logic [6:0] PWM_STEPS = 7'h64;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DLY_ENGAGE = 8'h04;
	localparam logic [7:0] OFS_DLY_HOLD = 8'h08;
	localparam logic [7:0] OFS_DLY_RELEASE = 8'h0c;
	localparam logic [7:0] OFS_DLY_SETTLE = 8'h10;
	localparam logic [7:0] OFS_PWM_FREQ = 8'h14;
	localparam logic [7:0] OFS_PWM_DUTY = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1c;
	localparam logic [7:0] OFS_DOUT = 8'h20;

	// field positions
	localparam int unsigned AUTO_BIT = 2;
	localparam int unsigned MANUAL_BRAKE_BIT = 0;

	// delay table indices
	localparam int unsigned DLY_ENGAGE = 0;
	localparam int unsigned DLY_HOLD = 1;
	localparam int unsigned DLY_RELEASE = 2;
	localparam int unsigned DLY_SETTLE = 3;

	// reset values
	localparam logic RST_AUTO = 1'b1;
	localparam logic [15:0] RST_DELAY = 16'h0000;
	localparam logic [15:0] RST_FREQ = 16'h07d0;
	localparam logic [7:0] RST_DUTY = 8'h64;

	// pwm configuration carried to the generator
	typedef struct packed {
		logic [15:0] freq;
		logic [7:0] duty;
	} brake_cfg_t;

	// brake sequencing states
	typedef enum logic [2:0] {
		ST_OFF,
		ST_RELEASE_WAIT,
		ST_SETTLE,
		ST_RUN,
		ST_STOP,
		ST_ENGAGE_WAIT,
		ST_HOLD_WAIT
	} seq_state_t;

endpackage

//--- brake_pwm_gen.sv
// brake_pwm_gen: percent-step pwm generator for the brake output
// assumes cfg is already clamped to the legal frequency and duty ranges
`timescale 1ns/1ps

module brake_pwm_gen (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic en,
	input wire brake_pkg::brake_cfg_t cfg,
	output logic pwm_q
);

	logic [26:0] acc_q; // fractional step accumulator
	logic [26:0] acc_d;
	logic [6:0] step_q; // position inside the period, 0..99
	logic [6:0] step_d;
	brake_pkg::brake_cfg_t lat_q; // settings in force this period
	brake_pkg::brake_cfg_t lat_d;
	logic pwm_d;
	logic [26:0] sum;
	logic tick;

	////////////////////////////////////////////////////////////////
	// next-value logic: step rate is freq*100 steps per second
	always_comb begin
		sum = acc_q + 27'(lat_q.freq) * 27'(brake_pkg::PWM_STEPS);
		tick = (sum >= 27'(brake_pkg::CLK_HZ));
		acc_d = tick ? sum - 27'(brake_pkg::CLK_HZ) : sum;
		step_d = step_q;
		lat_d = lat_q;
		if (!en) begin
			// idle: restart the period and follow the settings
			acc_d = '0;
			step_d = '0;
			lat_d = cfg;
		end else if (tick) begin
			if (step_q == brake_pkg::PWM_STEPS - 7'h01) begin
				// [RULE10] new settings at boundary
				step_d = '0;
				lat_d = cfg;
			end else begin
				step_d = step_q + 7'h01;
			end
		end
		// [RULE6] modulate while switched on
		// [RULE9] duty 100 keeps output high
		pwm_d = en && ({1'b0, step_d} < lat_d.duty);
	end

	// registers only
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			acc_q <= '0;
			step_q <= '0;
			lat_q <= '{freq: brake_pkg::RST_FREQ, duty: brake_pkg::RST_DUTY};
			pwm_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			step_q <= step_d;
			lat_q <= lat_d;
			pwm_q <= pwm_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// checks
	a_pwm_needs_en: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE6
		!en |=> !pwm_q) else $error("brake pwm high while brake switched off");
	a_full_duty_on: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE9
		(en && lat_q.duty == brake_pkg::DUTY_MAX && cfg.duty == brake_pkg::DUTY_MAX) [*2] |=> pwm_q)
		else $error("duty 100 did not hold brake output on");
	a_settings_boundary: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE10
		$changed(lat_q) |-> $past(!en || (tick && step_q == brake_pkg::PWM_STEPS - 7'h01)))
		else $error("pwm settings changed inside a period");

endmodule

//--- brake_load_model.sv
// brake_load_model: holding brake coil seen from the brake output
// assumes brake_pwm is a registered level from the design, high = coil energised
`timescale 1ns/1ps

module brake_load_model (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic brake_pwm,
	output logic [31:0] hi_len,
	output logic [31:0] per_len,
	output logic [31:0] n_rise
);
	logic prev_q; // coil drive one cycle ago
	logic [31:0] age_q; // cycles since the last rising edge
	logic [31:0] run_q; // cycles of the present high pulse

	////////////////////////////////////////////////////////////////
	// measure period between rises and width of each high pulse
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			prev_q <= 1'b0;
			age_q <= 32'h0;
			run_q <= 32'h0;
			hi_len <= 32'h0;
			per_len <= 32'h0;
			n_rise <= 32'h0;
		end else begin
			prev_q <= brake_pwm;
			// a rise closes one period and opens the next
			if (brake_pwm && !prev_q) begin
				per_len <= age_q;
				age_q <= 32'h1;
				n_rise <= n_rise + 32'h1;
			end else begin
				age_q <= age_q + 32'h1;
			end
			// pulse width is latched when the coil is let go
			if (brake_pwm) begin
				run_q <= prev_q ? run_q + 32'h1 : 32'h1;
			end else if (prev_q) begin
				hi_len <= run_q;
			end
		end
	end
endmodule

//--- test_brake_sequencer_pwm.sv
// test_brake_sequencer_pwm: self-checking bench for the brake sequencer
// assumes brake_load_model beside it; the millisecond base is cut to 4 cycles
`timescale 1ns/1ps

module test_brake_sequencer_pwm;
	localparam int unsigned MSC = 4; // cycles per ms in simulation
	localparam int LIMIT = 95000; // cycle ceiling for the run
	localparam int PER = brake_pkg::CLK_HZ / 2000; // cycles per pwm period at 2 kHz
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic op_enable = 1'b0;
	logic motor_standstill = 1'b0;
	logic [31:0] reg_rdata_q;
	logic motor_current_q, travel_enable_q, stop_request_q, brake_pwm;
	logic [31:0] hi_len, per_len, n_rise; // figures from the brake model
	logic [31:0] d, duty;
	logic [31:0] dly [4]; // random delays in ms, by delay index
	int n_fail = 0;
	int n_checks = 0;
	int cyc = 0;
	int n;
	bit ok;

	// free-running core clock
	always #12.5 core_clk = ~core_clk;

	brake_sequencer_pwm #(.MS_CYCLES(MSC)) i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .op_enable(op_enable),
		.motor_standstill(motor_standstill), .reg_rdata_q(reg_rdata_q), .motor_current_q(motor_current_q),
		.travel_enable_q(travel_enable_q), .stop_request_q(stop_request_q), .brake_pwm(brake_pwm));
	brake_load_model i_brake (.core_clk(core_clk), .sys_rst(sys_rst), .brake_pwm(brake_pwm), .hi_len(hi_len),
		.per_len(per_len), .n_rise(n_rise));

	////////////////////////////////////////////////////////////////
	// closing report
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// hang guard
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			n_fail++;
			test_done();
		end
	end

	// exact compare
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// window compare for counted cycles
	task automatic chk_rng(input int v, input int lo, input int hi);
		n_checks++;
		if (v < lo || v > hi) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, v, lo);
		end
	endtask

	////////////////////////////////////////////////////////////////
	// register port cycles
	task automatic wr(input logic [7:0] a, input logic [31:0] w);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= w;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata_q, e);
	endtask

	// counts cycles until an output reaches a level
	task automatic wait_for(input int sel, input logic lvl, output int cnt);
		logic s;
		cnt = 0;
		do begin
			@(posedge core_clk);
			#1;
			cnt++;
			case (sel)
				0: s = brake_pwm;
				1: s = travel_enable_q;
				default: s = motor_current_q;
			endcase
		end while (s !== lvl && cnt < 200);
	endtask

	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		void'($urandom(29));
		repeat (16) @(posedge core_clk);
		sys_rst <= 1'b0;
		// reset values, unmapped read, clamping corners
		rdchk(brake_pkg::OFS_CTRL, 32'h4);
		rdchk(brake_pkg::OFS_STATUS, 32'h0);
		rdchk(brake_pkg::OFS_DOUT, 32'h0);
		rdchk(8'h24, 32'h0);
		rdchk(brake_pkg::OFS_PWM_DUTY, 32'h64);
		rdchk(brake_pkg::OFS_PWM_FREQ, 32'h7d0);
		wr(brake_pkg::OFS_PWM_FREQ, 32'hbb8);
		rdchk(brake_pkg::OFS_PWM_FREQ, 32'h7d0);
		wr(brake_pkg::OFS_PWM_FREQ, 32'h0);
		rdchk(brake_pkg::OFS_PWM_FREQ, 32'h1);
		wr(brake_pkg::OFS_PWM_FREQ, 32'h7d0);
		wr(brake_pkg::OFS_PWM_DUTY, 32'h1);
		rdchk(brake_pkg::OFS_PWM_DUTY, 32'h2);
		wr(brake_pkg::OFS_PWM_DUTY, 32'h65);
		rdchk(brake_pkg::OFS_PWM_DUTY, 32'h64);
		// random delays: reset value, then readback
		for (int i = 0; i < 4; i++) begin
			dly[i] = 32'($urandom_range(4, 1));
			rdchk(8'(4 * i + 4), 32'h0);
			wr(8'(4 * i + 4), dly[i]);
			rdchk(8'(4 * i + 4), dly[i]);
		end
		// auto mode idle keeps brake closed, then power-up order
		repeat (10) @(posedge core_clk);
		#1 chk(32'(brake_pwm), 32'h0);
		@(posedge core_clk);
		op_enable <= 1'b1;
		@(posedge core_clk);
		#1 chk(32'(motor_current_q), 32'h1);
		chk(32'(brake_pwm), 32'h0);
		wait_for(0, 1'b1, n);
		chk_rng(n, dly[2] * MSC, dly[2] * MSC + 4);
		chk(32'(travel_enable_q), 32'h0);
		wait_for(1, 1'b1, n);
		chk_rng(n, dly[3] * MSC - 1, dly[3] * MSC + 3);
		// running state: 3, brake on, current on, travel on, enable seen
		rdchk(brake_pkg::OFS_STATUS, 32'h173);
		// power-down order waits for standstill first
		@(posedge core_clk);
		op_enable <= 1'b0;
		@(posedge core_clk);
		#1 chk(32'(stop_request_q), 32'h1);
		chk(32'(travel_enable_q), 32'h0);
		repeat (20) @(posedge core_clk);
		motor_standstill <= 1'b1;
		#1 chk(32'(brake_pwm), 32'h1);
		wait_for(0, 1'b0, n);
		chk_rng(n, dly[0] * MSC, dly[0] * MSC + 5);
		chk(32'(motor_current_q), 32'h1);
		wait_for(2, 1'b0, n);
		chk_rng(n, dly[1] * MSC - 1, dly[1] * MSC + 4);
		@(posedge core_clk);
		motor_standstill <= 1'b0;
		// enable withdrawn inside the release delay: brake must stay shut
		d = n_rise;
		op_enable <= 1'b1;
		@(posedge core_clk);
		op_enable <= 1'b0;
		wait_for(2, 1'b0, n);
		chk_rng(n, dly[1] * MSC, dly[1] * MSC + 4);
		chk(n_rise, d);
		// manual mode follows the output bit; duty 100 is steady
		wr(brake_pkg::OFS_CTRL, 32'h0);
		wr(brake_pkg::OFS_DOUT, 32'h1);
		wait_for(0, 1'b1, n);
		chk_rng(n, 1, 4);
		ok = 1'b1;
		repeat (500) begin
			@(posedge core_clk);
			#1 if (brake_pwm !== 1'b1) ok = 1'b0;
		end
		chk(32'(ok), 32'h1);
		wr(brake_pkg::OFS_DOUT, 32'h0);
		wait_for(0, 1'b0, n);
		chk_rng(n, 1, 4);
		// random duty at 2 kHz, measured by the brake model
		duty = 32'($urandom_range(50, 2));
		wr(brake_pkg::OFS_PWM_DUTY, duty);
		wr(brake_pkg::OFS_DOUT, 32'h1);
		d = n_rise;
		n = 0;
		while (n_rise !== d + 32'h3 && n < 70000) begin
			@(posedge core_clk);
			#1 n++;
		end
		chk_rng(per_len, PER - 1, PER + 1);
		chk_rng(hi_len, duty * (PER / 100) - 1, duty * (PER / 100) + 1);
		test_done();
	end
endmodule
